/* File: logic/fst_scan_timer.sv */
// frequency scan step timer with apb register access
// assumes an apb master on pclk and a waveform-cycle pulse input
//
// Functional notes
// R1: no stop frequency, end is start plus N steps
// R2: 12-bit increment count from tag 0001 words
// R3: host writes increment count 2 to 4095
// R4: interval bit D13 picks waveform or clock base
// R5: interval tag 01, dwell count in D10..D0
// R6: host writes dwell count at least 2
// R7: hold each frequency dwell count base intervals
// R8: D12..D11 multiplier 1, 5, 100, 500
// R9: clock base interval is clock period times multiplier
// R10: scan lasts one plus count intervals
// R11: dwell sets time at each frequency
// R12: start frequency first, then signed steps
// R13: step sign from D11 of high step word
// R14: after last interval, hold done until restarted; an abort write also drops done and returns to idle
`timescale 1ns/10ps
`default_nettype none
module fst_scan_timer
  import fst_pkg::*;
(
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  wave_tick,
  output logic      [FST_FREQ_W-1:0] scan_freq,
  output logic                       freq_step,
  output logic                       scan_busy,
  output logic                       scan_done
);
  // apb answer registers
  logic [31:0]            prdata_q;
  logic                   pready_q;
  logic                   pslverr_q;
  // configuration
  logic [FST_COUNT_W-1:0] incr_count_q;
  fst_interval_type       interval_q;
  logic [FST_STEP_W-1:0]  step_q;
  logic                   step_neg_q;
  logic [FST_FREQ_W-1:0]  start_q;
  // scan state
  fst_state_type          state_q;
  fst_state_type          state_d;
  logic [FST_FREQ_W-1:0]  freq_q;
  logic [FST_FREQ_W-1:0]  freq_d;
  logic [FST_COUNT_W-1:0] remain_q;
  logic [FST_STEP_W-1:0]  run_step_q;
  logic                   run_neg_q;
  logic                   step_pulse_q;
  logic [FST_COUNT_W:0]   intervals_q;
  logic [FST_COUNT_W-1:0] snap_count_q;
  logic [FST_FREQ_W-1:0]  snap_start_q;

  // bus decode
  logic                   acc_req;
  logic                   acc_fire;
  logic                   hit_cmd;
  logic                   hit_ctrl;
  logic                   hit_stat;
  logic                   hit_freq;
  logic                   hit_cfg;
  logic                   mapped;
  logic                   wr_cmd;
  logic                   wr_ctrl;
  logic [3:0]             tag;
  logic                   start_req;
  logic                   abort_req;
  logic [31:0]            rd_mux;
  logic                   interval_done;
  logic                   last_interval;
  logic                   advance;
  logic [FST_FREQ_W-1:0]  step_ext;

  assign acc_req  = psel && penable && !pready_q;
  assign acc_fire = psel && penable && pready_q;
  assign hit_cmd  = (paddr == FST_CMD_OFS);
  assign hit_ctrl = (paddr == FST_CTRL_OFS);
  assign hit_stat = (paddr == FST_STAT_OFS);
  assign hit_freq = (paddr == FST_FREQ_OFS);
  assign hit_cfg  = (paddr == FST_CFG_OFS);
  assign mapped   = hit_cmd || hit_ctrl || hit_stat || hit_freq || hit_cfg;
  assign wr_cmd   = acc_fire && pwrite && hit_cmd;
  assign wr_ctrl  = acc_fire && pwrite && hit_ctrl;
  assign tag      = pwdata[FST_TAG_MSB:FST_TAG_LSB];
  assign start_req = wr_ctrl && pwdata[FST_CTRL_START_BIT];
  assign abort_req = wr_ctrl && pwdata[FST_CTRL_ABORT_BIT] && !start_req;

  always_comb begin
    rd_mux = '0;
    if (hit_stat) begin
      rd_mux[FST_STAT_BUSY_BIT] = (state_q == FST_RUN);
      rd_mux[FST_STAT_DONE_BIT] = (state_q == FST_DONE);
      rd_mux[FST_STAT_REM_LSB +: FST_COUNT_W] = remain_q;
    end else if (hit_freq) begin
      rd_mux[FST_FREQ_W-1:0] = freq_q;
    end else if (hit_cfg) begin
      rd_mux[FST_COUNT_W-1:0] = incr_count_q;
      rd_mux[FST_CFG_INTV_LSB +: $bits(fst_interval_type)] = interval_q;
    end
  end

  // one wait state, then answer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= '0;
    end else begin
      pready_q  <= acc_req;
      pslverr_q <= acc_req && !mapped;
      prdata_q  <= (acc_req && !pwrite) ? rd_mux : '0;
    end
  end

  // R2 increment count load
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      incr_count_q <= FST_COUNT_RST;
    end else if (wr_cmd && tag == FST_TAG_COUNT) begin
      incr_count_q <= pwdata[FST_COUNT_W-1:0];
    end
  end

  // R5 interval word load, R4 R8 fields
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      interval_q <= '{base_clock: 1'b0, mult: 2'h0, count: FST_DWELL_RST};
    end else if (wr_cmd && pwdata[FST_TAG_MSB:FST_INTV_LSB] == FST_TAG_INTV) begin
      interval_q.base_clock <= pwdata[FST_BASE_BIT];
      interval_q.mult       <= pwdata[FST_MULT_MSB:FST_MULT_LSB];
      interval_q.count      <= pwdata[FST_DWELL_MSB:0];
    end
  end

  // R13 step halves and sign
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_q     <= '0;
      step_neg_q <= 1'b0;
    end else if (wr_cmd && tag == FST_TAG_STEP_LO) begin
      step_q[FST_HALF_MSB:0] <= pwdata[FST_HALF_MSB:0];
    end else if (wr_cmd && tag == FST_TAG_STEP_HI) begin
      step_q[FST_STEP_W-1:FST_HALF_MSB+1] <= pwdata[FST_STEP_HI_MSB:0];
      step_neg_q <= pwdata[FST_SIGN_BIT];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_q <= '0;
    end else if (wr_cmd && tag == FST_TAG_START_LO) begin
      start_q[FST_HALF_MSB:0] <= pwdata[FST_HALF_MSB:0];
    end else if (wr_cmd && tag == FST_TAG_START_HI) begin
      start_q[FST_FREQ_W-1:FST_HALF_MSB+1] <= pwdata[FST_HALF_MSB:0];
    end
  end

  // R11 dwell timer paces every frequency
  fst_dwell_timer u_dwell (
    .pclk          (pclk),
    .presetn       (presetn),
    .restart       (start_req),
    .cfg           (interval_q),
    .wave_tick     (wave_tick),
    .interval_done (interval_done)
  );

  assign last_interval = (remain_q == '0);
  assign advance       = (state_q == FST_RUN) && interval_done && !start_req && !abort_req;
  assign step_ext      = {1'b0, run_step_q};

  always_comb begin
    state_d = state_q;
    freq_d  = freq_q;
    case (state_q)
      FST_IDLE: begin
        state_d = FST_IDLE;
      end
      FST_RUN: begin
        // R1 R14 last interval ends, no stop value
        if (advance && last_interval) begin
          state_d = FST_DONE;
        // R12 signed step per interval
        end else if (advance) begin
          freq_d = run_neg_q ? freq_q - step_ext : freq_q + step_ext;
        end
      end
      FST_DONE: begin
        state_d = FST_DONE;
      end
      default: begin
        state_d = FST_IDLE;
      end
    endcase
    if (start_req) begin
      state_d = FST_RUN;
      freq_d  = start_q;
    end else if (abort_req) begin
      state_d = FST_IDLE;
    end
  end

  // R10 one start interval plus count steps
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q     <= FST_IDLE;
      freq_q      <= '0;
      remain_q    <= '0;
      run_step_q  <= '0;
      run_neg_q   <= 1'b0;
      intervals_q <= '0;
    end else begin
      state_q <= state_d;
      freq_q  <= freq_d;
      if (start_req) begin
        remain_q    <= incr_count_q;
        run_step_q  <= step_q;
        run_neg_q   <= step_neg_q;
        intervals_q <= '0;
      end else if (advance) begin
        intervals_q <= intervals_q + 13'h0001;
        if (!last_interval) begin
          remain_q <= remain_q - 12'h001;
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      step_pulse_q <= 1'b0;
      snap_count_q <= '0;
      snap_start_q <= '0;
    end else begin
      step_pulse_q <= start_req || (advance && !last_interval);
      if (start_req) begin
        snap_count_q <= incr_count_q;
        snap_start_q <= start_q;
      end
    end
  end

  assign prdata    = prdata_q;
  assign pready    = pready_q;
  assign pslverr   = pslverr_q;
  assign scan_freq = freq_q;
  assign freq_step = step_pulse_q;
  assign scan_busy = (state_q == FST_RUN);
  assign scan_done = (state_q == FST_DONE);

  // expected end frequency
  logic [34:0]           exp_span;
  logic [FST_FREQ_W-1:0] exp_final;
  assign exp_span  = {23'h000000, snap_count_q} * {12'h000, run_step_q};
  assign exp_final = run_neg_q ? snap_start_q - exp_span[FST_FREQ_W-1:0]
                               : snap_start_q + exp_span[FST_FREQ_W-1:0];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_final_step;
    (state_q == FST_RUN) && advance && last_interval;
  endsequence

  AST_APB_ANSWER: assert property (
    acc_req |=> pready_q ##1 !pready_q)
    else $error("apb answer not exactly one cycle after access");

  AST_FINAL_FREQ: assert property ( // R1
    s_final_step |=> (state_q == FST_DONE) && (freq_q == exp_final))
    else $error("scan ended at wrong frequency");

  AST_COUNT_LOAD: assert property ( // R2
    (wr_cmd && tag == FST_TAG_COUNT) |=> incr_count_q == $past(pwdata[FST_COUNT_W-1:0]))
    else $error("increment count not loaded");

  AST_INTV_LOAD: assert property ( // R5
    (wr_cmd && pwdata[FST_TAG_MSB:FST_INTV_LSB] == FST_TAG_INTV)
      |=> interval_q.count == $past(pwdata[FST_DWELL_MSB:0])
          && interval_q.base_clock == $past(pwdata[FST_BASE_BIT]))
    else $error("interval word not loaded");

  AST_SCAN_LEN: assert property ( // R10
    s_final_step |-> intervals_q == {1'b0, snap_count_q})
    else $error("scan length is not one plus count intervals");

  AST_FREQ_HOLD: assert property ( // R11
    (!start_req && !advance) |=> $stable(freq_q))
    else $error("frequency changed inside a dwell interval");

  AST_SIGNED_STEP: assert property ( // R12
    (advance && !last_interval)
      |=> freq_q == ($past(run_neg_q) ? $past(freq_q) - $past(step_ext)
                                      : $past(freq_q) + $past(step_ext)))
    else $error("step not applied with its sign");

  AST_SIGN_LOAD: assert property ( // R13
    (wr_cmd && tag == FST_TAG_STEP_HI) |=> step_neg_q == $past(pwdata[FST_SIGN_BIT]))
    else $error("step sign not taken from high word");

  AST_DONE_HOLD: assert property ( // R14
    (state_q == FST_DONE && !start_req && !abort_req)
      |=> (state_q == FST_DONE) && $stable(freq_q))
    else $error("completed scan did not hold");

  sequence s_start_taken;
    start_req;
  endsequence

  sequence s_scan_opened;
    (state_q == FST_RUN) && step_pulse_q && (freq_q == $past(start_q));
  endsequence

  AST_START_LOAD: assert property ( // R12
    s_start_taken |=> s_scan_opened)
    else $error("scan did not open at the start frequency");

  AST_APB_ERR: assert property (
    pslverr_q |-> pready_q)
    else $error("error response without ready");

  AST_RD_IDLE: assert property (
    !pready_q |-> (prdata_q == '0))
    else $error("read data not zero outside the answer cycle");

  AST_REMAIN_STEP: assert property ( // R10
    (advance && !last_interval) |=> remain_q == $past(remain_q) - 12'h001)
    else $error("remaining increments not counted down");

  AST_ABORT_IDLE: assert property ( // R14
    abort_req |=> (state_q == FST_IDLE) && !step_pulse_q)
    else $error("abort did not return to idle");

  AST_IDLE_HOLD: assert property ( // R14
    (state_q == FST_IDLE && !start_req) |=> (state_q == FST_IDLE))
    else $error("idle left without a start");
endmodule // fst_scan_timer
`default_nettype wire

/* File: logic/fst_pkg.sv */
// shared constants and types of the frequency scan step timer
// assumes a 32-bit apb slave on a single 25 MHz clock
`default_nettype none
package fst_pkg;
  // apb byte offsets
  localparam logic [7:0]  FST_CMD_OFS        = 8'h00;
  localparam logic [7:0]  FST_CTRL_OFS       = 8'h04;
  localparam logic [7:0]  FST_STAT_OFS       = 8'h08;
  localparam logic [7:0]  FST_FREQ_OFS       = 8'h0C;
  localparam logic [7:0]  FST_CFG_OFS        = 8'h10;
  // command word tags and field positions
  localparam int          FST_TAG_MSB        = 15;
  localparam int          FST_TAG_LSB        = 12;
  localparam int          FST_INTV_LSB       = 14;
  localparam logic [3:0]  FST_TAG_COUNT      = 4'h1;
  localparam logic [3:0]  FST_TAG_STEP_LO    = 4'h2;
  localparam logic [3:0]  FST_TAG_STEP_HI    = 4'h3;
  localparam logic [3:0]  FST_TAG_START_LO   = 4'hC;
  localparam logic [3:0]  FST_TAG_START_HI   = 4'hD;
  localparam logic [1:0]  FST_TAG_INTV       = 2'h1;
  localparam int          FST_BASE_BIT       = 13;
  localparam int          FST_MULT_MSB       = 12;
  localparam int          FST_MULT_LSB       = 11;
  localparam int          FST_DWELL_MSB      = 10;
  localparam int          FST_SIGN_BIT       = 11;
  localparam int          FST_HALF_MSB       = 11;
  localparam int          FST_STEP_HI_MSB    = 10;
  // widths
  localparam int          FST_FREQ_W         = 24;
  localparam int          FST_STEP_W         = 23;
  localparam int          FST_COUNT_W        = 12;
  localparam int          FST_DWELL_W        = 11;
  localparam int          FST_PRE_W          = 9;
  // time-base multiplier terminal counts
  localparam logic [8:0]  FST_MULT_X1        = 9'h001;
  localparam logic [8:0]  FST_MULT_X5        = 9'h005;
  localparam logic [8:0]  FST_MULT_X100      = 9'h064;
  localparam logic [8:0]  FST_MULT_X500      = 9'h1F4;
  // control and status bits
  localparam int          FST_CTRL_START_BIT = 0;
  localparam int          FST_CTRL_ABORT_BIT = 1;
  localparam int          FST_STAT_BUSY_BIT  = 0;
  localparam int          FST_STAT_DONE_BIT  = 1;
  localparam int          FST_STAT_REM_LSB   = 16;
  localparam int          FST_CFG_INTV_LSB   = 16;
  // reset values
  localparam logic [11:0] FST_COUNT_RST      = 12'h002;
  localparam logic [10:0] FST_DWELL_RST      = 11'h002;

  typedef struct packed {
    logic        base_clock;
    logic [1:0]  mult;
    logic [10:0] count;
  } fst_interval_type;

  typedef enum logic [1:0] {
    FST_IDLE = 2'b00,
    FST_RUN  = 2'b01,
    FST_DONE = 2'b10
  } fst_state_type;
endpackage
`default_nettype wire

/* File: logic/fst_dwell_timer.sv */
// dwell interval timer: counts base intervals up to the dwell count
// assumes wave_tick is a one-cycle pulse per output waveform cycle
`timescale 1ns/10ps
`default_nettype none
module fst_dwell_timer
  import fst_pkg::*;
(
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             restart,
  input  wire fst_interval_type cfg,
  input  wire logic             wave_tick,
  output logic                  interval_done
);
  logic [FST_PRE_W-1:0]   pre_q;
  logic [FST_DWELL_W-1:0] dwell_q;
  logic [FST_PRE_W-1:0]   term;
  logic                   pre_wrap;
  logic                   base_tick;
  logic                   dwell_last;

  // R8 multiplier code to count
  assign term = (cfg.mult == 2'h0) ? FST_MULT_X1 :
                (cfg.mult == 2'h1) ? FST_MULT_X5 :
                (cfg.mult == 2'h2) ? FST_MULT_X100 : FST_MULT_X500;
  // R9 base interval in clocks
  assign pre_wrap   = (pre_q == term - FST_MULT_X1);
  // R4 waveform or clock base
  assign base_tick  = !restart && (cfg.base_clock ? pre_wrap : wave_tick);
  // R7 dwell count of base intervals
  assign dwell_last = (dwell_q == cfg.count - 11'h001);
  // unregistered end: with the clock base the first interval after restart is as long as the rest
  assign interval_done = base_tick && dwell_last;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q   <= '0;
      dwell_q <= '0;
    end else if (restart) begin
      pre_q   <= '0;
      dwell_q <= '0;
    end else begin
      if (cfg.base_clock) begin
        pre_q <= pre_wrap ? '0 : pre_q + 9'h001;
      end
      if (base_tick) begin
        dwell_q <= dwell_last ? '0 : dwell_q + 11'h001;
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_WAVE_BASE: assert property ( // R4
    (!cfg.base_clock && !wave_tick) |-> !base_tick)
    else $error("base interval advanced without a waveform cycle");

  AST_MULT_TERM: assert property ( // R8
    (cfg.base_clock && base_tick) |-> (pre_q == term - FST_MULT_X1))
    else $error("clock base interval length differs from multiplier");

  AST_DWELL_END: assert property ( // R7
    interval_done |=> (dwell_q == '0))
    else $error("interval did not end after dwell count");
endmodule // fst_dwell_timer
`default_nettype wire

/* File: dv/fst_host_model.sv */
// host side model: apb master tasks and a periodic waveform-cycle pulse
// assumes the bench timeout ends a transfer that is never answered
`timescale 1ns/10ps
`default_nettype none
module fst_host_model #(
  parameter int WAVE_DIV = 4
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             wave_tick
);
  int tick_cnt;

  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  // free-running output waveform: one pulse every WAVE_DIV clocks
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt  <= 0;
      wave_tick <= 1'b0;
    end else begin
      tick_cnt  <= (tick_cnt == WAVE_DIV - 1) ? 0 : tick_cnt + 1;
      wave_tick <= (tick_cnt == WAVE_DIV - 1);
    end
  end

  // one apb transfer, request held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule // fst_host_model
`default_nettype wire

/* File: dv/tb.sv */
// self-checking bench of the scan step timer
// assumes the host model drives apb and the waveform-cycle pulse
`timescale 1ns/10ps
`default_nettype none
module tb;
  import fst_pkg::*;
  localparam int WDIV = 4;
  logic                  pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic                  wave_tick, freq_step, scan_busy, scan_done, err, neg, mon, clk_base;
  logic [7:0]            paddr;
  logic [31:0]           pwdata, prdata, rd;
  logic [FST_FREQ_W-1:0] scan_freq, exp_f, exp_end;
  logic [22:0]           mag;
  int                    n_errors, checks_done, cyc, n_seen, exp_n, exp_t, tmo;

  fst_host_model #(.WAVE_DIV(WDIV)) u_fst_host_model (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .wave_tick(wave_tick));

  fst_scan_timer u_fst_scan_timer (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wave_tick(wave_tick), .scan_freq(scan_freq),
    .freq_step(freq_step), .scan_busy(scan_busy), .scan_done(scan_done));

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_fst_host_model.xfer(1'b1, a, d, rd, err);
  endtask

  task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] msk,
                       input logic [31:0] exp);
    u_fst_host_model.xfer(1'b0, a, 32'h0000_0000, rd, err);
    check(what, rd & msk, exp);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // program one scan, start it and let the monitor follow it to the end
  task automatic run_scan(input string nm, input logic [23:0] s, input logic [22:0] m,
                          input logic sg, input logic [11:0] n, input logic [13:0] iv,
                          input int t);
    wr(FST_CMD_OFS, {16'h0000, 4'hC, s[11:0]});
    wr(FST_CMD_OFS, {16'h0000, 4'hD, s[23:12]});
    wr(FST_CMD_OFS, {16'h0000, 4'h2, m[11:0]});
    // sign in bit 11 of the upper step word
    wr(FST_CMD_OFS, {16'h0000, 4'h3, sg, m[22:12]});
    // count word, host keeps it at 2 or more
    wr(FST_CMD_OFS, {16'h0000, 4'h1, n});
    // interval word, dwell of 2 or more
    wr(FST_CMD_OFS, {16'h0000, 2'b01, iv});
    mag = m;
    neg = sg;
    clk_base = iv[FST_BASE_BIT];
    exp_f = s;
    exp_t = t;
    exp_n = int'(n);
    exp_end = sg ? s - 24'(n) * 24'(m) : s + 24'(n) * 24'(m);
    n_seen = 0;
    mon = 1'b1;
    wr(FST_CTRL_OFS, 32'h0000_0001);
    while (mon) @(posedge pclk);
    repeat (20) @(posedge pclk);
    check("done held", {31'h0, scan_done}, 32'h1);
    check("final freq held", {8'h00, scan_freq}, {8'h00, exp_end});
    rdchk("stat busy done", FST_STAT_OFS, 32'h3, 32'h2);
    $display("test %s done", nm);
  endtask

  // follows each frequency of a running scan
  always @(posedge pclk) begin
    tmo++;
    if (tmo == 60000) begin
      n_errors++;
      close_out();
    end
    cyc++;
    if (mon && freq_step) begin
      // the first waveform-base interval starts at an arbitrary waveform phase
      if (n_seen > 1 || (n_seen > 0 && clk_base)) begin
        check("dwell cycles", cyc, exp_t);
      end
      check("step freq", {8'h00, scan_freq}, {8'h00, exp_f});
      exp_f = neg ? exp_f - 24'(mag) : exp_f + 24'(mag);
      n_seen++;
      cyc = 0;
    end else if (mon && n_seen > 0 && scan_done) begin
      check("last dwell", cyc, exp_t);
      check("intervals", n_seen, exp_n + 1);
      check("end freq", {8'h00, scan_freq}, {8'h00, exp_end});
      mon = 1'b0;
    end
  end

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  initial begin
    presetn = 1'b0;
    mon = 1'b0;
    n_errors = 0;
    checks_done = 0;
    tmo = 0;
    cyc = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    rdchk("cfg reset", FST_CFG_OFS, 32'hFFFF_FFFF, 32'h0002_0002);
    rdchk("freq reset", FST_FREQ_OFS, 32'hFFFF_FFFF, 32'h0);
    rdchk("unmapped", 8'h20, 32'hFFFF_FFFF, 32'h0);
    check("unmapped err", {31'h0, err}, 32'h1);
    wr(FST_CFG_OFS, 32'hFFFF_FFFF);
    rdchk("cfg read only", FST_CFG_OFS, 32'hFFFF_FFFF, 32'h0002_0002);
    $display("test registers done");
    run_scan("x1", 24'h123456, 23'h401001, 1'b0, 12'h002, 14'h2003, 3);
    run_scan("x5 down", 24'h000010, 23'h000020, 1'b1, 12'h003, 14'h2802, 10);
    run_scan("x100", 24'h000100, 23'h000001, 1'b0, 12'h002, 14'h3002, 200);
    run_scan("x500", 24'h000100, 23'h000003, 1'b0, 12'h002, 14'h3802, 1000);
    run_scan("wave", 24'h000200, 23'h000005, 1'b0, 12'h002, 14'h1802, 2 * WDIV);
    run_scan("dwell max", 24'h000000, 23'h000001, 1'b0, 12'h002, 14'h27FF, 2047);
    run_scan("count max", 24'h000000, 23'h000001, 1'b0, 12'hFFF, 14'h2002, 2);
    wr(FST_CMD_OFS, 32'h0000_6032);
    wr(FST_CTRL_OFS, 32'h0000_0001);
    repeat (10) @(posedge pclk);
    rdchk("stat running", FST_STAT_OFS, 32'h0FFF_0003, 32'h0FFF_0001);
    wr(FST_CTRL_OFS, 32'h0000_0002);
    repeat (2) @(posedge pclk);
    check("abort idle", {30'h0, scan_busy, scan_done}, 32'h0);
    $display("test abort done");
    close_out();
  end
endmodule // tb
`default_nettype wire
